// file: hw/msc_regs_map.vh
`ifndef MSC_REGS_MAP_VH
`define MSC_REGS_MAP_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define MSC_ADDR_RATE_X_HIGH  7'h43
`define MSC_ADDR_RATE_X_LOW   7'h44
`define MSC_ADDR_RATE_Y_HIGH  7'h45
`define MSC_ADDR_RATE_Y_LOW   7'h46
`define MSC_ADDR_RATE_Z_HIGH  7'h47
`define MSC_ADDR_RATE_Z_LOW   7'h48
`define MSC_ADDR_PATH_RESET   7'h68
`define MSC_ADDR_MOTION_CTRL  7'h69
`define MSC_ADDR_HOST_CTRL    7'h6A

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MSC_BIT_ACCEL_PATH_RST   1
`define MSC_BIT_TEMP_PATH_RST    0
`define MSC_BIT_MOTION_ENABLE    7
`define MSC_BIT_MOTION_COMPARE   6
`define MSC_BIT_MOTION_RSVD0     0
`define MSC_BIT_FIFO_SERIAL_EN   6
`define MSC_BIT_TWO_WIRE_DISABLE 4
`define MSC_BIT_FIFO_RESET       2
`define MSC_BIT_ALL_PATHS_RESET  0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MSC_RST_RESULT   16'h0000
`define MSC_RST_CTRL     8'h00

// ----------------------------------------------------------------
// timing and scale
// ----------------------------------------------------------------
`define MSC_CLOCK_MHZ        250
`define MSC_INT_CLOCK_MHZ    20
// one internal-clock period in ns, then in system cycles (rounded up)
`define MSC_FIFO_RST_NS      (1000 / `MSC_INT_CLOCK_MHZ)
`define MSC_FIFO_RST_CYCLES  ((`MSC_FIFO_RST_NS * `MSC_CLOCK_MHZ + 999) / 1000)
// nominal counts per deg/s at rate range select zero
`define MSC_RATE_SENS_FS0    131

`endif

// file: hw/msc_regs.v
// Summary of operation
// [R01] X rate result, 16 bits: high byte at 0x43, low byte at 0x44.
// [R02] Y rate result, 16 bits: high byte at 0x45, low byte at 0x46.
// [R03] Z rate result, 16 bits: high byte at 0x47, low byte at 0x48.
// [R04] Result is sensitivity times rate: 131 counts per deg/s at range 0.
// [R05] Path reset bit 1 resets accel path; accel results keep contents.
// [R06] Path reset bit 0 resets temperature path; temperature results kept.
// [R07] Motion control bit 7 switches wake-on-motion detection on or off.
// [R08] Motion bit 6: 0 compares with first sample, 1 with previous one.
// [R09] Host writes zero to motion control bit 0 when motion wake is on.
// [R10] Host bit 6 enables FIFO; clear blocks serial FIFO access only.
// [R11] Host control bit 4 disables two-wire target, leaving SPI only.
// [R12] Host control bit 2 resets FIFO, self-clears after one 20 MHz cycle.
// [R13] Host control bit 0 resets all sensor paths and clears all results.
// [R14] Writes to the rate result registers change nothing.
`include "msc_regs_map.vh"
`timescale 1ns/1ps
`default_nettype none

module msc_regs #(
   parameter DATA_W       = 16,
   parameter [15:0] MOTION_THRESHOLD = 16'h0100,
   parameter FIFO_RST_CYC = `MSC_FIFO_RST_CYCLES
) (
   input  wire              clock,
   input  wire              reset_n,
   input  wire [6:0]        regAddr,
   input  wire              regWrite,
   input  wire              regRead,
   input  wire [7:0]        regWrData,
   output reg  [7:0]        regRdData,
   output reg               regRdValid,
   input  wire              rateValid,
   input  wire [DATA_W-1:0] rateX,
   input  wire [DATA_W-1:0] rateY,
   input  wire [DATA_W-1:0] rateZ,
   input  wire              accelValid,
   input  wire [DATA_W-1:0] accelX,
   input  wire [DATA_W-1:0] accelY,
   input  wire [DATA_W-1:0] accelZ,
   output reg               accelPathReset,
   output reg               tempPathReset,
   output reg               allPathsReset,
   output reg               fifoReset,
   output reg               fifoSerialEnable,
   output reg               twoWireDisable,
   output reg               motionDetectEnable,
   output reg               motionWake
);

   // ----------------------------------------------------------------
   // operating notes
   // ----------------------------------------------------------------
   // register port
   //    one address per cycle, write, read or both
   //    read answered one edge after the request edge
   //    read data holds until the next read
   //    read and write in one cycle: the read sees the old value
   //    unmapped offsets read zero, writes there are dropped
   //
   // rate results
   //    samples arrive already scaled by the sensitivity
   //    no latching between high and low byte reads
   //    a sample between two byte reads may tear the pair
   //    host writes to the result offsets never reach storage
   //
   // path resets
   //    accel and temperature bits are one-cycle pulses
   //    they leave every stored result as it is
   //    the path reset offset always reads zero
   //
   // all-paths reset
   //    clears the rate results even against a new sample
   //    also pulses the accel and temperature path resets
   //    also drops the motion reference
   //
   // fifo reset
   //    stretched to one internal-clock period of system cycles
   //    reads back one while the stretch runs
   //    a new write restarts the stretch
   //
   // motion wake
   //    first sample after enable only loads the reference
   //    threshold compares the magnitude of the difference
   //    any axis above the threshold raises one wake pulse
   //    reference mode follows the compare select bit
   //
   // control outputs
   //    every level output is a registered copy of its bit
   //    so a write shows two edges after the request edge
   //    all outputs sit low during reset and its release
   //
   // hazards
   //    the counter width limits the stretch to 255 cycles
   //    reference mode change while enabled takes effect at once
   //    the reserved motion bit is stored but has no effect

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   reg        rstSync1_q;
   reg        rstSync2_q;
   wire       rstN;

   // two-flop release of the asynchronous reset
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rstSync1_q <= 1'b0;
         rstSync2_q <= 1'b0;
      end else begin
         rstSync1_q <= 1'b1;
         rstSync2_q <= rstSync1_q;
      end
   end
   assign rstN = rstSync2_q;

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   // true when a host write targets the given offset
   function hitW;
      input [6:0] addr;
      input       wr;
      input [6:0] target;
      begin
         hitW = wr && (addr == target);
      end
   endfunction

   // true when two samples differ by more than the threshold
   function exceeds;
      input [DATA_W-1:0] a;
      input [DATA_W-1:0] b;
      reg   [DATA_W:0]   diff;
      begin
         diff = {a[DATA_W-1], a} - {b[DATA_W-1], b};
         if (diff[DATA_W])
            diff = (~diff) + {{DATA_W{1'b0}}, 1'b1};
         exceeds = (diff > {1'b0, MOTION_THRESHOLD[DATA_W-1:0]});
      end
   endfunction

   wire wrPath   = hitW(regAddr, regWrite, `MSC_ADDR_PATH_RESET);
   wire wrMotion = hitW(regAddr, regWrite, `MSC_ADDR_MOTION_CTRL);
   wire wrHost   = hitW(regAddr, regWrite, `MSC_ADDR_HOST_CTRL);
   wire clrAll   = wrHost && regWrData[`MSC_BIT_ALL_PATHS_RESET];

   // ----------------------------------------------------------------
   // rate result registers
   // ----------------------------------------------------------------
   reg  [DATA_W-1:0] rateResult_q [0:2];
   wire [DATA_W-1:0] rateIn       [0:2];

   assign rateIn[0] = rateX;
   assign rateIn[1] = rateY;
   assign rateIn[2] = rateZ;

   // samples arrive already scaled by the sensitivity; no host write path
   genvar ax;
   generate
      for (ax = 0; ax < 3; ax = ax + 1) begin : gRate
         always @(posedge clock or negedge rstN) begin
            if (!rstN) begin
               rateResult_q[ax] <= `MSC_RST_RESULT;
            end else if (clrAll) begin
               rateResult_q[ax] <= `MSC_RST_RESULT; // R13
            end else if (rateValid) begin
               rateResult_q[ax] <= rateIn[ax]; // R04
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   reg        motionEnable_q;
   reg        motionCompare_q;
   reg        motionRsvd0_q;
   reg        fifoSerialEn_q;
   reg        twoWireDis_q;
   reg        fifoRstBit_q;
   reg [7:0]  fifoRstCnt_q;

   // motion detect control, stored as written
   always @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         motionEnable_q  <= 1'b0;
         motionCompare_q <= 1'b0;
         motionRsvd0_q   <= 1'b0;
      end else if (wrMotion) begin
         motionEnable_q  <= regWrData[`MSC_BIT_MOTION_ENABLE]; // R07
         motionCompare_q <= regWrData[`MSC_BIT_MOTION_COMPARE]; // R08
         motionRsvd0_q   <= regWrData[`MSC_BIT_MOTION_RSVD0]; // R09
      end
   end

   // host control persistent bits
   always @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         fifoSerialEn_q <= 1'b0;
         twoWireDis_q   <= 1'b0;
      end else if (wrHost) begin
         fifoSerialEn_q <= regWrData[`MSC_BIT_FIFO_SERIAL_EN]; // R10
         twoWireDis_q   <= regWrData[`MSC_BIT_TWO_WIRE_DISABLE]; // R11
      end
   end

   // fifo reset bit held for one internal-clock period, then self-clears
   always @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         fifoRstBit_q <= 1'b0;
         fifoRstCnt_q <= 8'h00;
      end else if (wrHost && regWrData[`MSC_BIT_FIFO_RESET]) begin
         fifoRstBit_q <= 1'b1; // R12
         fifoRstCnt_q <= FIFO_RST_CYC[7:0];
      end else if (fifoRstBit_q) begin
         if (fifoRstCnt_q == 8'h01) begin
            fifoRstBit_q <= 1'b0; // R12
            fifoRstCnt_q <= 8'h00;
         end else begin
            fifoRstCnt_q <= fifoRstCnt_q - 8'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // path reset and control outputs
   // ----------------------------------------------------------------
   // one-cycle path reset pulses; result registers here are untouched
   always @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         accelPathReset <= 1'b0;
         tempPathReset  <= 1'b0;
         allPathsReset  <= 1'b0;
      end else begin
         accelPathReset <= (wrPath &&
            regWrData[`MSC_BIT_ACCEL_PATH_RST]) || clrAll; // R05
         tempPathReset  <= (wrPath &&
            regWrData[`MSC_BIT_TEMP_PATH_RST]) || clrAll; // R06
         allPathsReset  <= clrAll; // R13
      end
   end

   // registered copies of the control bits
   always @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         fifoReset          <= 1'b0;
         fifoSerialEnable   <= 1'b0;
         twoWireDisable     <= 1'b0;
         motionDetectEnable <= 1'b0;
      end else begin
         fifoReset          <= fifoRstBit_q; // R12
         fifoSerialEnable   <= fifoSerialEn_q; // R10
         twoWireDisable     <= twoWireDis_q; // R11
         motionDetectEnable <= motionEnable_q; // R07
      end
   end

   // ----------------------------------------------------------------
   // wake-on-motion comparator
   // ----------------------------------------------------------------
   reg  [DATA_W-1:0] refX_q;
   reg  [DATA_W-1:0] refY_q;
   reg  [DATA_W-1:0] refZ_q;
   reg               refValid_q;
   wire              moved;

   assign moved = exceeds(accelX, refX_q) || exceeds(accelY, refY_q) ||
                  exceeds(accelZ, refZ_q);

   // reference is the first sample, or the previous one in compare mode
   always @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         refX_q     <= `MSC_RST_RESULT;
         refY_q     <= `MSC_RST_RESULT;
         refZ_q     <= `MSC_RST_RESULT;
         refValid_q <= 1'b0;
         motionWake <= 1'b0;
      end else if (!motionEnable_q || clrAll) begin
         refValid_q <= 1'b0; // R07
         motionWake <= 1'b0;
      end else begin
         motionWake <= 1'b0;
         if (accelValid) begin
            if (!refValid_q || motionCompare_q) begin
               refX_q <= accelX; // R08
               refY_q <= accelY;
               refZ_q <= accelZ;
            end
            refValid_q <= 1'b1;
            motionWake <= refValid_q && moved; // R08
         end
      end
   end

   // ----------------------------------------------------------------
   // register read port
   // ----------------------------------------------------------------
   reg [7:0] rdMux;

   // read decode; unmapped offsets and unused bits read zero, the reserved motion bit reads back as stored
   always @* begin
      case (regAddr)
         `MSC_ADDR_RATE_X_HIGH: rdMux = rateResult_q[0][15:8]; // R01
         `MSC_ADDR_RATE_X_LOW:  rdMux = rateResult_q[0][7:0]; // R01
         `MSC_ADDR_RATE_Y_HIGH: rdMux = rateResult_q[1][15:8]; // R02
         `MSC_ADDR_RATE_Y_LOW:  rdMux = rateResult_q[1][7:0]; // R02
         `MSC_ADDR_RATE_Z_HIGH: rdMux = rateResult_q[2][15:8]; // R03
         `MSC_ADDR_RATE_Z_LOW:  rdMux = rateResult_q[2][7:0]; // R03
         `MSC_ADDR_MOTION_CTRL: begin
            rdMux = 8'h00;
            rdMux[`MSC_BIT_MOTION_ENABLE]  = motionEnable_q;
            rdMux[`MSC_BIT_MOTION_COMPARE] = motionCompare_q;
            rdMux[`MSC_BIT_MOTION_RSVD0]   = motionRsvd0_q;
         end
         `MSC_ADDR_HOST_CTRL: begin
            rdMux = 8'h00;
            rdMux[`MSC_BIT_FIFO_SERIAL_EN]   = fifoSerialEn_q;
            rdMux[`MSC_BIT_TWO_WIRE_DISABLE] = twoWireDis_q;
            rdMux[`MSC_BIT_FIFO_RESET]       = fifoRstBit_q;
         end
         default: rdMux = 8'h00;
      endcase
   end

   // read data registered, valid one cycle after the request
   always @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         regRdData  <= 8'h00;
         regRdValid <= 1'b0;
      end else begin
         regRdValid <= regRead;
         if (regRead)
            regRdData <= rdMux;
      end
   end

   // writes to 0x43..0x48 decode to nothing: R14

endmodule // msc_regs

`default_nettype wire

// file: verif/msc_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// port checker
// ------------------------------
module msc_regs_monitor #(
   parameter FIFO_RST_CYC = 13
) (
   input wire logic        clock,
   input wire logic        reset_n,
   input wire logic [6:0]  regAddr,
   input wire logic        regWrite,
   input wire logic        regRead,
   input wire logic [7:0]  regWrData,
   input wire logic [7:0]  regRdData,
   input wire logic        regRdValid,
   input wire logic        rateValid,
   input wire logic [15:0] rateX,
   input wire logic [15:0] rateZ,
   input wire logic        accelPathReset,
   input wire logic        allPathsReset,
   input wire logic        fifoReset,
   input wire logic        twoWireDisable,
   input wire logic        motionDetectEnable,
   input wire logic        motionWake
);
   logic [7:0]  highCnt_q;
   logic [15:0] shX_q;
   logic [15:0] shZ_q;
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   // fifo reset length and shadow copies of the X and Z rate results
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         highCnt_q <= 8'h00;
         shX_q     <= 16'h0000;
         shZ_q     <= 16'h0000;
      end else begin
         highCnt_q <= fifoReset ? highCnt_q + 8'h01 : 8'h00;
         shX_q <= allPathsReset ? 16'h0000 : rateValid ? rateX : shX_q;
         shZ_q <= allPathsReset ? 16'h0000 : rateValid ? rateZ : shZ_q;
      end
   end
   a_read_answer: assert property (regRead |=> regRdValid)
      else $error("read not answered");
   a_rate_x_high: assert property (
      regRead && !rateValid && regAddr == 7'h43 |=> regRdData == shX_q[15:8])
      else $error("x high byte wrong");
   a_rate_z_low: assert property (
      regRead && !rateValid && regAddr == 7'h48 |=> regRdData == shZ_q[7:0])
      else $error("z low byte wrong");
   a_fifo_rst_start: assert property (
      regWrite && regAddr == 7'h6A && regWrData[2] |-> ##2 fifoReset)
      else $error("fifo reset not raised");
   a_fifo_rst_len: assert property ($fell(fifoReset) |->
      highCnt_q == FIFO_RST_CYC) else $error("fifo reset length wrong");
   a_two_wire_lvl: assert property (regWrite && regAddr == 7'h6A
      |-> ##2 twoWireDisable == $past(regWrData[4], 2))
      else $error("two wire disable wrong");
   a_motion_en_lvl: assert property (regWrite && regAddr == 7'h69
      |-> ##2 motionDetectEnable == $past(regWrData[7], 2))
      else $error("motion enable wrong");
   a_accel_rst_pulse: assert property (
      regWrite && regAddr == 7'h68 && regWrData[1] |=> accelPathReset)
      else $error("accel path reset missing");
   a_all_paths_pulse: assert property (
      regWrite && regAddr == 7'h6A && regWrData[0]
      |=> allPathsReset && accelPathReset)
      else $error("all paths reset missing");
   c_fifo_done: cover property ($fell(fifoReset));
   c_wake: cover property (motionWake);
   c_all_paths: cover property (allPathsReset);
endmodule // msc_regs_monitor
bind msc_regs msc_regs_monitor #(.FIFO_RST_CYC(FIFO_RST_CYC)) u_mon (
   .clock(clock), .reset_n(reset_n), .regAddr(regAddr),
   .regWrite(regWrite), .regRead(regRead), .regWrData(regWrData),
   .regRdData(regRdData), .regRdValid(regRdValid), .rateValid(rateValid),
   .rateX(rateX), .rateZ(rateZ), .accelPathReset(accelPathReset),
   .allPathsReset(allPathsReset), .fifoReset(fifoReset),
   .twoWireDisable(twoWireDisable),
   .motionDetectEnable(motionDetectEnable), .motionWake(motionWake));
`default_nettype wire

// file: verif/msc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// host side of the register port
// ------------------------------
module msc_host_model (
   input  wire logic       clock,
   input  wire logic [7:0] regRdData,
   input  wire logic       regRdValid,
   output var  logic [6:0] regAddr,
   output var  logic       regWrite,
   output var  logic       regRead,
   output var  logic [7:0] regWrData
);
   // idle port at time zero
   initial begin
      regAddr   = 7'h00;
      regWrite  = 1'b0;
      regRead   = 1'b0;
      regWrData = 8'h00;
   end
   // one write strobe, reserved motion bit kept clear
   task wr(input logic [6:0] a, input logic [7:0] dat);
      @(negedge clock);
      regAddr   = a;
      regWrData = (a == 7'h69) ? (dat & 8'hFE) : dat;
      regWrite  = 1'b1;
      @(negedge clock);
      regWrite  = 1'b0;
      regAddr   = ~a;
      regWrData = ~regWrData;
   endtask
   // one read strobe, answer awaited a bounded time
   task rd(input logic [6:0] a, output logic [7:0] dat, output logic ok);
      ok  = 1'b0;
      dat = 8'h00;
      @(negedge clock);
      regAddr = a;
      regRead = 1'b1;
      @(negedge clock);
      regRead = 1'b0;
      regAddr = ~a;
      repeat (4) begin
         if (!ok && regRdValid === 1'b1) begin
            ok  = 1'b1;
            dat = regRdData;
         end
         if (!ok) @(negedge clock);
      end
   endtask
endmodule // msc_host_model
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// bench top
// ------------------------------
module tb_top;
   logic        clock, reset_n, rateValid, accelValid;
   logic [15:0] rateX, rateY, rateZ, accelX;
   wire  [6:0]  regAddr;
   wire  [7:0]  regWrData, regRdData;
   wire         regWrite, regRead, regRdValid, accelPathReset, tempPathReset;
   wire         allPathsReset, fifoReset, fifoSerialEnable, twoWireDisable;
   wire         motionDetectEnable, motionWake;
   integer      num_errors, comparisons, seed, i, j, wakes;
   logic [7:0]  d, e;
   logic [6:0]  a;
   logic [15:0] v [0:2];
   msc_regs #(.FIFO_RST_CYC(4)) dut (.clock(clock), .reset_n(reset_n),
      .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
      .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
      .rateValid(rateValid), .rateX(rateX), .rateY(rateY), .rateZ(rateZ),
      .accelValid(accelValid), .accelX(accelX), .accelY(accelX),
      .accelZ(accelX), .accelPathReset(accelPathReset),
      .tempPathReset(tempPathReset), .allPathsReset(allPathsReset),
      .fifoReset(fifoReset), .fifoSerialEnable(fifoSerialEnable),
      .twoWireDisable(twoWireDisable),
      .motionDetectEnable(motionDetectEnable), .motionWake(motionWake));
   msc_host_model host (.clock(clock), .regRdData(regRdData),
      .regRdValid(regRdValid), .regAddr(regAddr), .regWrite(regWrite),
      .regRead(regRead), .regWrData(regWrData));
   // compare and count
   task check(input string name, input logic [15:0] seen,
              input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // closing report
   task give_verdict;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // read one register, a lost answer ends the run
   task rd(input logic [6:0] ra);
      logic ok;
      host.rd(ra, d, ok);
      if (!ok) begin
         num_errors++;
         give_verdict;
      end
   endtask
   // one accel sample, wake pulses counted
   task sample(input logic [15:0] x);
      @(negedge clock);
      accelValid = 1'b1;
      accelX = x;
      @(negedge clock);
      accelValid = 1'b0;
      accelX = ~x;
      if (motionWake === 1'b1) wakes++;
   endtask
   // rate counts for a turn rate in deg/s at range zero
   function automatic logic [15:0] scaled(input integer dps);
      return 16'(131 * dps);
   endfunction
   // free running clock
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   // main sequence
   initial begin
      seed = 32'h045D27B5;
      {num_errors, comparisons, wakes} = 0;
      {reset_n, rateValid, accelValid, rateX, rateY, rateZ, accelX} = 0;
      repeat (20) @(negedge clock);
      reset_n = 1'b1;
      repeat (4) @(negedge clock);
      // random samples read back byte by byte, result writes ignored
      for (i = 0; i < 20; i++) begin
         host.wr(7'(8'h43 + i % 6), 8'($random(seed)));
         v[0] = (i == 0) ? scaled(250) : scaled($random(seed) % 250);
         v[1] = (i == 1) ? 16'h8000 : 16'($random(seed));
         v[2] = (i == 2) ? 16'hFFFF : 16'($random(seed));
         @(negedge clock);
         {rateX, rateY, rateZ} = {v[0], v[1], v[2]};
         rateValid = 1'b1;
         @(negedge clock);
         rateValid = 1'b0;
         for (j = 0; j < 6; j++) begin
            rd(7'(8'h43 + j));
            e = j % 2 ? v[j / 2][7:0] : v[j / 2][15:8];
            check("rate", d, e);
         end
      end
      // single path resets keep the results
      host.wr(7'h68, 8'h03);
      check("path pulses", {accelPathReset, tempPathReset}, 3);
      rd(7'h68);
      check("path reg", d, 0);
      rd(7'h44);
      check("kept x low", d, v[0][7:0]);
      // fifo gate, spi only and fifo reset
      host.wr(7'h6A, 8'h54);
      @(negedge clock);
      check("fifo reset on", fifoReset, 1);
      check("fifo serial", fifoSerialEnable, 1);
      check("spi only", twoWireDisable, 1);
      repeat (4) @(negedge clock);
      check("fifo reset off", fifoReset, 0);
      host.wr(7'h6A, 8'h00);
      @(negedge clock);
      check("levels off", {fifoSerialEnable, twoWireDisable}, 0);
      rd(7'h10);
      check("unmapped", d, 0);
      // wake on motion, first-sample then previous-sample reference
      for (i = 0; i < 3; i++) begin
         host.wr(7'h69, 8'h00);
         host.wr(7'h69, i == 0 ? 8'h81 : i == 1 ? 8'hC1 : 8'h00);
         @(negedge clock);
         check("motion enable", motionDetectEnable, i < 2);
         wakes = 0;
         sample(16'h0000);
         sample(16'h00F0);
         sample(i == 2 ? 16'h7000 : 16'h01E0);
         check("wake count", 16'(wakes), i == 0);
      end
      // all paths reset clears every result
      host.wr(7'h6A, 8'h01);
      check("all pulses", {allPathsReset, tempPathReset}, 3);
      repeat (3) @(negedge clock);
      for (j = 0; j < 6; j++) begin
         rd(7'(8'h43 + j));
         check("cleared", d, 0);
      end
      give_verdict;
   end
endmodule // tb_top
`default_nettype wire
